// ### nib_dec_map.svh
// Constants for the nibble prefix instruction decoder: offsets, codes, timing.
`ifndef NIB_DEC_MAP_SVH
`define NIB_DEC_MAP_SVH
// ****************************************************************
// Widths and start state
// ****************************************************************
`define WORD_W        32
`define FP_W          64
`define START_ADDR    32'h00000100
`define START_WSP     32'h00000800
// ****************************************************************
// Function codes, one fixed mapping of all sixteen  [RULE17]
// ****************************************************************
`define FN_JUMP       4'h0
`define FN_LOCAL_PTR  4'h1
`define FN_PREFIX     4'h2
`define FN_LOAD_NL    4'h3
`define FN_LOAD_CONST 4'h4
`define FN_NL_PTR     4'h5
`define FN_NEG_PREFIX 4'h6
`define FN_LOAD_LOCAL 4'h7
`define FN_ADD_CONST  4'h8
`define FN_CALL       4'h9
`define FN_COND_JUMP  4'ha
`define FN_ADJ_WS     4'hb
`define FN_EQ_CONST   4'hc
`define FN_STORE_LOC  4'hd
`define FN_STORE_NL   4'he
`define FN_OPERATE    4'hf
// ****************************************************************
// Operate selectors; common ones sit below sixteen  [RULE17]
// ****************************************************************
`define OP_REV        32'h00000000
`define OP_ADD        32'h00000005
`define OP_GT         32'h00000009
`define OP_SUB        32'h0000000c
`define OP_AND        32'h00000003
`define OP_OR         32'h00000004
`define OP_XOR        32'h00000006
`define OP_DUP        32'h00000007
`define OP_FP_LOAD    32'h00000001
`define OP_FP_STORE   32'h00000002
`define OP_FP_REV     32'h00000008
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ       250
`define HI_LAT_FAST_NS 2500
`define HI_LAT_SLOW_NS 3700
`define HI_LAT_CYC    ((`HI_LAT_FAST_NS * `CLK_MHZ) / 1000)
`define WAIT_W        10
`endif

// ### nib_dec_pkg.sv
// Types shared by the nibble prefix instruction decoder files.
package nib_dec_pkg;
	// Operations that a three-entry register stack can perform.
	typedef enum logic [2:0] {
		STK_HOLD, STK_PUSH, STK_POP, STK_POP2, STK_SWAP, STK_SET_TOP, STK_POP_SET
	} stack_op_type;
	// Instruction byte offered by program memory.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} instr_in_type;
	// Record of one completed instruction.
	typedef struct packed {
		logic        valid;
		logic [3:0]  func;
		logic [31:0] operand;
	} exec_type;
	// Memory command issued by a load or store.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        fp;
		logic [31:0] addr;
		logic [63:0] data;
	} mem_cmd_type;
	// View of the integer stack.
	typedef struct packed {
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
	} int_stack_type;
	// View of one floating-point stack copy.
	typedef struct packed {
		logic [63:0] fp_stack_top;
		logic [63:0] fp_stack_second;
		logic [63:0] fp_stack_third;
	} fp_stack_type;
endpackage

// ### reg_stack3.sv
// Three-entry register stack with push, pop, swap and top replacement.
`timescale 1ns/1ps
`default_nettype none
module reg_stack3 #(
	parameter int W = 32
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_b,
	input  wire logic                      i_ce,
	input  wire nib_dec_pkg::stack_op_type i_op,
	input  wire logic [W-1:0]              i_value,
	output logic      [W-1:0]              o_top,
	output logic      [W-1:0]              o_second,
	output logic      [W-1:0]              o_third
);
	import nib_dec_pkg::*;
	// Push moves second to third and top to second before the write.
	// Pop moves second to top and third to second; third keeps its value.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_top    <= '0;
			o_second <= '0;
			o_third  <= '0;
		end else if (i_ce) begin
			case (i_op)
				STK_PUSH: begin
					o_third  <= o_second;
					o_second <= o_top;
					o_top    <= i_value;
				end
				STK_POP: begin
					o_top    <= o_second;
					o_second <= o_third;
				end
				STK_POP2: begin
					o_top <= o_third;
				end
				STK_SWAP: begin
					o_top    <= o_second;
					o_second <= o_top;
				end
				STK_SET_TOP: begin
					o_top <= i_value;
				end
				STK_POP_SET: begin
					o_top    <= i_value;
					o_second <= o_third;
				end
				default: begin
					o_top <= o_top;
				end
			endcase
		end
	end
endmodule // reg_stack3
`default_nettype wire

// ### prio_sched.sv
// Two-level priority selection taken at instruction boundaries.
`timescale 1ns/1ps
`default_nettype none
`include "nib_dec_map.svh"
module prio_sched (
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	input  wire logic i_ce,
	input  wire logic i_step,
	input  wire logic i_boundary,
	input  wire logic i_hi_ready,
	input  wire logic i_lo_ready,
	output logic      o_priority
);
	import nib_dec_pkg::*;
	// ****************************************************************
	// Selection
	// ****************************************************************
	logic [`WAIT_W-1:0] wait_count; // Steps a ready high process has waited.
	wire                next_priority;
	wire                waiting;
	// High wins whenever ready; low runs only when no high is ready.
	assign next_priority = i_hi_ready ? 1'b1 : (i_lo_ready ? 1'b0 : o_priority); // [RULE13]
	assign waiting = i_hi_ready & ~o_priority;
	// Priority changes only where no prefix chain is in flight.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_priority <= 1'b0;
		end else if (i_ce && i_boundary) begin
			o_priority <= next_priority; // [RULE13]
		end
	end
	// Counts accepted bytes while a high process waits for the switch.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			wait_count <= '0;
		end else if (i_ce) begin
			if (!waiting) begin
				wait_count <= '0;
			end else if (i_step && wait_count != '1) begin
				wait_count <= wait_count + `WAIT_W'h1;
			end
		end
	end
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wait_bound_a: assert property (wait_count <= `HI_LAT_CYC) // [RULE15]
		else $error("High priority waited longer than the latency bound.");
	switch_up_a: assert property (i_ce && i_boundary && i_hi_ready |=> o_priority) // [RULE13]
		else $error("Ready high priority process did not take the processor.");
endmodule // prio_sched
`default_nettype wire

// ### nibble_prefix_instruction_decoder.sv
// Byte instruction decoder with operand prefixing, register stacks and priority.
// Functional notes
// [RULE1] Byte splits into function and data nibble.
// [RULE2] Sixteen function codes decoded.
// [RULE3] Data nibble ORed into operand low bits.
// [RULE4] Non-prefix instructions clear the operand.
// [RULE5] Prefix loads nibble then shifts four.
// [RULE6] Negative prefix loads, inverts, shifts four.
// [RULE7] Prefix chains extend any function's operand.
// [RULE8] Operate uses operand as operation selector.
// [RULE9] Add and compare selectors below sixteen.
// [RULE10] Integer push: second to third, top down.
// [RULE11] Integer pop: second up, third up.
// [RULE12] Floating stack pushes and pops likewise.
// [RULE13] Ready high priority always runs first.
// [RULE14] One floating stack copy per priority.
// [RULE15] High priority latency within bound.
// [RULE16] Floating addresses come from integer stack.
// [RULE17] Function and selector codes fixed constants.
// [RULE18] Reset clears state, fetch from start.
`timescale 1ns/1ps
`default_nettype none
`include "nib_dec_map.svh"
module nibble_prefix_instruction_decoder (
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_b,
	input  wire logic                      i_ce,
	input  wire nib_dec_pkg::instr_in_type i_instr,
	input  wire logic [`WORD_W-1:0]        i_load_word,
	input  wire logic [`FP_W-1:0]          i_fp_word,
	input  wire logic                      i_hi_ready,
	input  wire logic                      i_lo_ready,
	output logic      [`WORD_W-1:0]        o_iptr,
	output logic      [`WORD_W-1:0]        o_operand,
	output nib_dec_pkg::exec_type          o_exec,
	output nib_dec_pkg::mem_cmd_type       o_mem,
	output nib_dec_pkg::int_stack_type     o_int_stack,
	output nib_dec_pkg::fp_stack_type      o_fp_lo,
	output nib_dec_pkg::fp_stack_type      o_fp_hi,
	output logic                           o_priority
);
	import nib_dec_pkg::*;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// True for the two functions that keep building the operand.
	function automatic logic is_prefix(input logic [3:0] f);
		is_prefix = (f == `FN_PREFIX) || (f == `FN_NEG_PREFIX);
	endfunction

	// ****************************************************************
	// Byte split and operand formation
	// ****************************************************************
	logic [`WORD_W-1:0] wsp;           // Workspace base for local accesses.
	wire                fire;          // A byte is taken this cycle.
	wire  [3:0]         func;          // Upper nibble: function code.
	wire  [3:0]         nib;           // Lower nibble: data value.
	wire  [`WORD_W-1:0] operand_now;   // Operand seen by this instruction.
	wire  [`WORD_W-1:0] pfx_next;      // Operand after a prefix.
	wire  [`WORD_W-1:0] nfx_next;      // Operand after a negative prefix.
	wire                prefix_now;    // This byte is a prefix.
	wire                boundary;      // A non-prefix instruction completes.
	assign fire        = i_ce & i_instr.valid;
	assign func        = i_instr.data[7:4]; // [RULE1]
	assign nib         = i_instr.data[3:0]; // [RULE1]
	// The low four bits are always zero here, so OR acts as a load.
	assign operand_now = o_operand | {28'h0, nib}; // [RULE3]
	assign pfx_next    = {operand_now[27:0], 4'h0}; // [RULE5] [RULE7]
	assign nfx_next    = {~operand_now[27:0], 4'h0}; // [RULE6] [RULE7]
	assign prefix_now  = is_prefix(func);
	assign boundary    = fire & ~prefix_now;

	// ****************************************************************
	// Integer stack view and derived values
	// ****************************************************************
	wire  [`WORD_W-1:0] int_a;         // Integer stack top.
	wire  [`WORD_W-1:0] int_b;         // Integer stack second.
	wire  [`WORD_W-1:0] int_c;         // Integer stack third.
	wire  [`WORD_W-1:0] seq_ptr;       // Address of the next byte.
	wire  [`WORD_W-1:0] jump_target;   // Relative jump destination.
	wire  [`WORD_W-1:0] local_addr;    // Workspace word address.
	wire  [`WORD_W-1:0] nl_addr;       // Word address relative to top.
	wire  [`WORD_W-1:0] gt_result;     // Signed second above top.
	wire  [`WORD_W-1:0] eq_result;     // Top equals operand.
	assign seq_ptr     = o_iptr + 32'h1;
	assign jump_target = seq_ptr + operand_now;
	assign local_addr  = wsp + {operand_now[29:0], 2'h0};
	assign nl_addr     = int_a + {operand_now[29:0], 2'h0};
	assign gt_result   = {31'h0, $signed(int_b) > $signed(int_a)};
	assign eq_result   = {31'h0, int_a == operand_now};

	// ****************************************************************
	// Instruction decode
	// ****************************************************************
	stack_op_type       int_op;        // Integer stack action.
	logic [`WORD_W-1:0] int_val;       // Value written to the integer top.
	stack_op_type       fp_op;         // Action on the active floating copy.
	logic               take_jump;     // Redirect the fetch pointer.
	logic               next_wsp_en;   // Move the workspace base.
	mem_cmd_type        next_mem;      // Memory command for this instruction.
	wire  [`FP_W-1:0]   fp_act_top;    // Top of the active floating copy.
	// Nothing happens unless a whole non-prefix instruction is taken.
	always_comb begin
		int_op      = STK_HOLD;
		int_val     = '0;
		fp_op       = STK_HOLD;
		take_jump   = 1'b0;
		next_wsp_en = 1'b0;
		next_mem    = '0;
		if (boundary) begin
			case (func) // [RULE2]
				`FN_JUMP: take_jump = 1'b1;
				`FN_LOCAL_PTR: begin
					int_op  = STK_PUSH; // [RULE10]
					int_val = local_addr;
				end
				`FN_LOAD_NL: begin
					int_op   = STK_SET_TOP;
					int_val  = i_load_word;
					next_mem = '{1'b1, 1'b0, 1'b0, nl_addr, 64'h0};
				end
				`FN_LOAD_CONST: begin
					int_op  = STK_PUSH; // [RULE10]
					int_val = operand_now;
				end
				`FN_NL_PTR: begin
					int_op  = STK_SET_TOP;
					int_val = nl_addr;
				end
				`FN_LOAD_LOCAL: begin
					int_op   = STK_PUSH; // [RULE10]
					int_val  = i_load_word;
					next_mem = '{1'b1, 1'b0, 1'b0, local_addr, 64'h0};
				end
				`FN_ADD_CONST: begin
					int_op  = STK_SET_TOP;
					int_val = int_a + operand_now;
				end
				`FN_CALL: begin
					take_jump = 1'b1;
					int_op    = STK_PUSH;
					int_val   = seq_ptr;
				end
				`FN_COND_JUMP: begin
					take_jump = (int_a == 32'h0);
					int_op    = (int_a == 32'h0) ? STK_HOLD : STK_POP;
				end
				`FN_ADJ_WS: next_wsp_en = 1'b1;
				`FN_EQ_CONST: begin
					int_op  = STK_SET_TOP;
					int_val = eq_result;
				end
				`FN_STORE_LOC: begin
					int_op   = STK_POP; // [RULE11]
					next_mem = '{1'b1, 1'b1, 1'b0, local_addr, {32'h0, int_a}};
				end
				`FN_STORE_NL: begin
					int_op   = STK_POP2;
					next_mem = '{1'b1, 1'b1, 1'b0, nl_addr, {32'h0, int_b}};
				end
				`FN_OPERATE: begin
					// The whole prefixed operand selects the operation.
					case (operand_now) // [RULE8] [RULE9]
						`OP_REV: int_op = STK_SWAP;
						`OP_ADD: begin
							int_op  = STK_POP_SET;
							int_val = int_b + int_a;
						end
						`OP_SUB: begin
							int_op  = STK_POP_SET;
							int_val = int_b - int_a;
						end
						`OP_GT: begin
							int_op  = STK_POP_SET;
							int_val = gt_result;
						end
						`OP_AND: begin
							int_op  = STK_POP_SET;
							int_val = int_b & int_a;
						end
						`OP_OR: begin
							int_op  = STK_POP_SET;
							int_val = int_b | int_a;
						end
						`OP_XOR: begin
							int_op  = STK_POP_SET;
							int_val = int_b ^ int_a;
						end
						`OP_DUP: begin
							int_op  = STK_PUSH;
							int_val = int_a;
						end
						`OP_FP_LOAD: begin
							// Address is consumed from the integer top.
							int_op   = STK_POP; // [RULE16]
							fp_op    = STK_PUSH; // [RULE12]
							next_mem = '{1'b1, 1'b0, 1'b1, int_a, 64'h0};
						end
						`OP_FP_STORE: begin
							int_op   = STK_POP; // [RULE16]
							fp_op    = STK_POP; // [RULE12]
							next_mem = '{1'b1, 1'b1, 1'b1, int_a, fp_act_top};
						end
						`OP_FP_REV: fp_op = STK_SWAP;
						default: int_op = STK_HOLD;
					endcase
				end
				default: int_op = STK_HOLD;
			endcase
		end
	end

	// ****************************************************************
	// Operand, fetch pointer and workspace
	// ****************************************************************
	// Prefixes keep the shifted operand; everything else leaves zero.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_operand <= '0; // [RULE18]
		end else if (fire) begin
			if (func == `FN_PREFIX) begin
				o_operand <= pfx_next; // [RULE5]
			end else if (func == `FN_NEG_PREFIX) begin
				o_operand <= nfx_next; // [RULE6]
			end else begin
				o_operand <= '0; // [RULE4]
			end
		end
	end
	// Fetch steps one byte, or jumps relative to the next byte.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_iptr <= `START_ADDR; // [RULE18]
			wsp    <= `START_WSP;
		end else if (fire) begin
			o_iptr <= take_jump ? jump_target : seq_ptr;
			wsp    <= next_wsp_en ? local_addr : wsp;
		end
	end
	// Completed instruction record and memory command, one cycle each.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_exec <= '0;
			o_mem  <= '0;
		end else if (i_ce) begin
			o_exec <= '{boundary, func, operand_now}; // [RULE3]
			o_mem  <= next_mem;
		end
	end

	// ****************************************************************
	// Register stacks
	// ****************************************************************
	// Integer stack, cleared by reset.
	reg_stack3 #(.W(`WORD_W)) u_int_stack (
		.i_clk    (i_clk),
		.i_rst_b  (i_rst_b),
		.i_ce     (i_ce),
		.i_op     (int_op),
		.i_value  (int_val),
		.o_top    (int_a),
		.o_second (int_b),
		.o_third  (int_c)
	);
	assign o_int_stack = '{int_a, int_b, int_c};
	fp_stack_type fp_view [2];   // Both floating copies, indexed by priority.
	stack_op_type fp_op_vec [2]; // Action routed to each copy.
	// Only the copy of the running priority moves; the other is kept.
	for (genvar p = 0; p < 2; p++) begin : g_fp
		assign fp_op_vec[p] = (o_priority == p[0]) ? fp_op : STK_HOLD; // [RULE14]
		reg_stack3 #(.W(`FP_W)) u_fp_stack (
			.i_clk    (i_clk),
			.i_rst_b  (i_rst_b),
			.i_ce     (i_ce),
			.i_op     (fp_op_vec[p]),
			.i_value  (i_fp_word),
			.o_top    (fp_view[p].fp_stack_top),
			.o_second (fp_view[p].fp_stack_second),
			.o_third  (fp_view[p].fp_stack_third)
		);
	end
	assign fp_act_top = fp_view[o_priority].fp_stack_top;
	assign o_fp_lo    = fp_view[0];
	assign o_fp_hi    = fp_view[1];

	// ****************************************************************
	// Priority selection
	// ****************************************************************
	prio_sched u_sched (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_ce       (i_ce),
		.i_step     (fire),
		.i_boundary (boundary),
		.i_hi_ready (i_hi_ready),
		.i_lo_ready (i_lo_ready),
		.o_priority (o_priority)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	prefix_shift_a: assert property (fire && func == `FN_PREFIX |=> // [RULE5]
		o_operand == {$past(o_operand[27:4]), $past(nib), 4'h0})
		else $error("Prefix did not load and shift the operand.");
	neg_prefix_a: assert property (fire && func == `FN_NEG_PREFIX |=> // [RULE6]
		o_operand == {~$past(o_operand[27:4]), ~$past(nib), 4'h0})
		else $error("Negative prefix did not invert and shift.");
	operand_clear_a: assert property (boundary |=> o_operand == 32'h0) // [RULE4]
		else $error("Operand not cleared after an instruction.");
	exec_operand_a: assert property (boundary |=> o_exec.valid && // [RULE3]
		o_exec.operand == ($past(o_operand) | {28'h0, $past(i_instr.data[3:0])}))
		else $error("Executed operand differs from the formed operand.");
	func_split_a: assert property (boundary |=> o_exec.func == $past(i_instr.data[7:4])) // [RULE1]
		else $error("Function code not taken from the upper nibble.");
	int_push_a: assert property (i_ce && int_op == STK_PUSH |=> // [RULE10]
		int_c == $past(int_b) && int_b == $past(int_a))
		else $error("Integer push ordering wrong.");
	int_pop_a: assert property (i_ce && int_op == STK_POP |=> // [RULE11]
		int_a == $past(int_b) && int_b == $past(int_c))
		else $error("Integer pop ordering wrong.");
	fp_keep_a: assert property (i_ce && o_priority |=> $stable(o_fp_lo)) // [RULE14]
		else $error("Low priority floating copy changed at high priority.");
	reset_state_a: assert property ($rose(i_rst_b) |-> o_operand == 32'h0 && // [RULE18]
		o_iptr == `START_ADDR && o_int_stack == '0)
		else $error("State not defined after reset.");
endmodule // nibble_prefix_instruction_decoder
`default_nettype wire

// ### nibble_prefix_instruction_decoder_test.sv
// Self-checking bench for the nibble prefix instruction decoder.
`timescale 1ns/1ps
`default_nettype none
`include "nib_dec_map.svh"
module nibble_prefix_instruction_decoder_test;
	import nib_dec_pkg::*;
	// ****************************************************************
	// Stimulus, outputs and reference state
	// ****************************************************************
	logic          i_clk       = 1'b0;  // Core clock.
	logic          i_rst_b     = 1'b0;  // Reset, active low.
	logic          i_ce        = 1'b1;  // Clock enable.
	instr_in_type  i_instr     = '0;    // Offered byte.
	logic [31:0]   i_load_word = '0;    // Integer load data.
	logic [63:0]   i_fp_word   = '0;    // Floating load data.
	logic          i_hi_ready  = 1'b0;  // High level ready.
	logic          i_lo_ready  = 1'b0;  // Low level ready.
	logic [31:0]   o_iptr;              // Fetch pointer.
	logic [31:0]   o_operand;           // Operand register.
	exec_type      o_exec;              // Completion record.
	mem_cmd_type   o_mem;               // Memory record.
	int_stack_type o_int_stack;         // Integer stack.
	fp_stack_type  o_fp_lo;             // Low level float copy.
	fp_stack_type  o_fp_hi;             // High level float copy.
	logic          o_priority;          // Running level.
	int            num_errors  = 0;     // Mismatches.
	int            cmp_count   = 0;     // Comparisons.
	int            cycles      = 0;     // Timeout count.
	logic [15:0]   lfsr        = 16'h0057; // Random source.
	logic [31:0]   mo, ma, mb, mc, mip, wsp, mv, maddr; // Model registers.
	logic          mp;                  // Model level.
	mem_cmd_type   mm;                  // Model memory record for the last byte.
	logic [63:0]   fs [2][3];           // Model float copies.
	logic [7:0]    b;                   // Working byte.
	logic [7:0]    walk [31] = '{8'h21, 8'h22, 8'h43, 8'h60, 8'h4f, 8'h45, 8'hf5, 8'hf9,
		8'hf0, 8'hf3, 8'hf4, 8'hf6, 8'hf7, 8'hfc, 8'hf8,
		8'h13, 8'h35, 8'h52, 8'h74, 8'h83, 8'hbc, 8'hc1, 8'hd0, 8'h00, 8'h95,
		8'ha2, 8'h47, 8'h47, 8'h47, 8'he0, 8'ha0};
	nibble_prefix_instruction_decoder dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_instr(i_instr), .i_load_word(i_load_word), .i_fp_word(i_fp_word),
		.i_hi_ready(i_hi_ready), .i_lo_ready(i_lo_ready), .o_iptr(o_iptr),
		.o_operand(o_operand), .o_exec(o_exec), .o_mem(o_mem), .o_int_stack(o_int_stack),
		.o_fp_lo(o_fp_lo), .o_fp_hi(o_fp_hi), .o_priority(o_priority));
	// Clock inverts every half period; the cycle counter cuts a hang short.
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			give_verdict();
		end
	end
	// ****************************************************************
	// Tasks
	// ****************************************************************
	// Sixteen-bit shift register step for random values.
	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Compares one value and counts it.
	task automatic chk(input logic [191:0] got, input logic [191:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Reference behaviour of one taken byte.
	task automatic model(input logic [7:0] x);
		mv = mo | {28'h0, x[3:0]};
		mo = 32'h0;
		mm = '0;
		mip = mip + 32'h1;
		case (x[7:4])
			4'h2: mo = mv << 4;
			4'h6: mo = (~mv) << 4;
			4'h0: mip = mip + mv;
			4'h1: begin mc = mb; mb = ma; ma = wsp + 4 * mv; end
			4'h3: begin
				mm = '{1'b1, 1'b0, 1'b0, ma + 4 * mv, 64'h0};
				ma = i_load_word;
			end
			4'h4: begin mc = mb; mb = ma; ma = mv; end
			4'h5: ma = ma + 4 * mv;
			4'h7: begin
				mm = '{1'b1, 1'b0, 1'b0, wsp + 4 * mv, 64'h0};
				mc = mb;
				mb = ma;
				ma = i_load_word;
			end
			4'h8: ma = ma + mv;
			4'h9: begin mc = mb; mb = ma; ma = mip; mip = mip + mv; end
			4'ha: if (ma == 0) mip = mip + mv; else begin ma = mb; mb = mc; end
			4'hb: wsp = wsp + 4 * mv;
			4'hc: ma = (ma == mv) ? 32'h1 : 32'h0;
			4'hd: begin
				mm = '{1'b1, 1'b1, 1'b0, wsp + 4 * mv, {32'h0, ma}};
				ma = mb;
				mb = mc;
			end
			4'he: begin
				mm = '{1'b1, 1'b1, 1'b0, ma + 4 * mv, {32'h0, mb}};
				ma = mc;
			end
			default: case (mv)
				0: {ma, mb} = {mb, ma};
				1: begin
					maddr = ma;
					mm = '{1'b1, 1'b0, 1'b1, ma, 64'h0};
					ma = mb;
					mb = mc;
					fs[mp][2] = fs[mp][1];
					fs[mp][1] = fs[mp][0];
					fs[mp][0] = i_fp_word;
				end
				2: begin
					mm = '{1'b1, 1'b1, 1'b1, ma, fs[mp][0]};
					ma = mb;
					mb = mc;
					fs[mp][0] = fs[mp][1];
					fs[mp][1] = fs[mp][2];
				end
				3: begin ma = mb & ma; mb = mc; end
				4: begin ma = mb | ma; mb = mc; end
				5: begin ma = mb + ma; mb = mc; end
				6: begin ma = mb ^ ma; mb = mc; end
				7: begin mc = mb; mb = ma; end
				8: {fs[mp][0], fs[mp][1]} = {fs[mp][1], fs[mp][0]};
				9: begin ma = ($signed(mb) > $signed(ma)) ? 1 : 0; mb = mc; end
				12: begin ma = mb - ma; mb = mc; end
				default: ;
			endcase
		endcase
		if (x[7:4] != 4'h2 && x[7:4] != 4'h6) begin
			if (i_hi_ready) mp = 1'b1;
			else if (i_lo_ready) mp = 1'b0;
		end
	endtask
	// Offers one byte, lets it be taken, then checks all results except the low float third and the high float second.
	task automatic issue(input logic [7:0] x);
		i_instr = {1'b1, x};
		i_load_word = {lfsr, ~lfsr};
		i_fp_word = {lfsr, 16'h5a5a, ~lfsr, lfsr};
		@(posedge i_clk);
		#1;
		model(x);
		lfsr = lfsr_next(lfsr);
		chk(o_operand, mo);
		chk(o_int_stack.a, ma);
		chk(o_int_stack.b, mb);
		chk(o_int_stack.c, mc);
		chk(o_iptr, mip);
		chk(o_exec.valid, x[7:4] != 4'h2 && x[7:4] != 4'h6);
		if (x[7:4] != 4'h2 && x[7:4] != 4'h6) chk({o_exec.func, o_exec.operand}, {x[7:4], mv});
		chk(o_mem, mm);
		chk(o_priority, mp);
		chk({o_fp_lo.fp_stack_top, o_fp_lo.fp_stack_second}, {fs[0][0], fs[0][1]});
		chk({o_fp_hi.fp_stack_top, o_fp_hi.fp_stack_third}, {fs[1][0], fs[1][2]});
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{mo, ma, mb, mc, mp, maddr} = '0;
		mip = `START_ADDR;
		wsp = `START_WSP;
		fs = '{default: 64'h0};
		repeat (8) @(posedge i_clk);
		#1;
		i_rst_b = 1'b1;
		chk({o_iptr, o_operand, o_int_stack}, {mip, 128'h0});
		$display("test reset done");
		foreach (walk[k]) issue(walk[k]);
		$display("test all codes done");
		for (int k = 0; k < 60; k++) begin
			b = lfsr[7:0];
			if (b[7:4] == 4'he) b[7:4] = 4'h4;
			if (b[7:4] == 4'hf) b[3:0] = lfsr[8] ? 4'h5 : 4'h9;
			i_hi_ready = lfsr[9];
			i_lo_ready = lfsr[10];
			issue(b);
		end
		$display("test random chains done");
		i_ce = 1'b0;
		i_instr = {1'b1, 8'h21};
		@(posedge i_clk);
		#1;
		chk({o_operand, o_iptr}, {mo, mip});
		i_ce = 1'b1;
		$display("test enable hold done");
		i_hi_ready = 1'b1;
		i_lo_ready = 1'b0;
		issue(8'h48);
		issue(8'hf1);
		chk({o_mem.valid, o_mem.fp, o_mem.addr}, {2'b11, maddr});
		i_hi_ready = 1'b0;
		i_lo_ready = 1'b1;
		issue(8'h4c);
		issue(8'hf1);
		chk(o_mem.addr, maddr);
		issue(8'hf8);
		issue(8'hf8);
		issue(8'hf2);
		i_instr = '0;
		$display("test float copies done");
		give_verdict();
	end
endmodule // nibble_prefix_instruction_decoder_test
`default_nettype wire
